// ---- design/tcmp_defs.svh ----
// Register offsets, field positions and reset values of the compare timer.
// Included by the timer module.
`ifndef TCMP_DEFS_SVH
`define TCMP_DEFS_SVH
`define TCMP_OFF_SEL   8'h00
`define TCMP_OFF_FORCE 8'h04
`define TCMP_OFF_MASK  8'h08
`define TCMP_OFF_DATA  8'h0C
`define TCMP_OFF_PORT  8'h10
`define TCMP_OFF_DIR   8'h14
`define TCMP_OFF_ACT   8'h18
`define TCMP_OFF_CTL   8'h1C
`define TCMP_OFF_CNT   8'h20
`define TCMP_OFF_FLAG  8'h24
`define TCMP_OFF_ACC   8'h28
`define TCMP_OFF_TC0   8'h40
`define TCMP_OFF_TC7   8'h5C
`define TCMP_CTL_EN    0
`define TCMP_CTL_PR_LO 1
`define TCMP_CTL_PR_HI 3
`define TCMP_CTL_ACC   4
`define TCMP_PR_MAX    3'h5
`define TCMP_RST_BYTE  8'h00
`define TCMP_RST_ACT   16'h0000
`define TCMP_RST_CTL   5'h00
`define TCMP_RST_WORD  16'h0000
`endif

// ---- design/tcmp_pkg.sv ----
// Types shared by the compare timer and its bench.
// Assumes tcmp_defs.svh on the include path.
package tcmp_pkg;
  // APB request from the bus master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } tcmp_apb_req_t;
  // Two-bit compare output action
  typedef enum logic [1:0] {
    TCMP_ACT_OFF = 2'h0,
    TCMP_ACT_TGL = 2'h1,
    TCMP_ACT_CLR = 2'h2,
    TCMP_ACT_SET = 2'h3
  } tcmp_act_t;
endpackage

// ---- design/tcmp_timer.sv ----
// Eight-channel capture/compare timer with timer port control and APB slave.
// Assumes one 20 MHz clock, synchronous reset, port pins from outside.
`include "tcmp_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tcmp_timer #(
  parameter int CW = 16
) (
  // Clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst,
  // APB slave
  input  wire tcmp_pkg::tcmp_apb_req_t i_apb,
  output logic [31:0]                 o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  // Timer port pins
  input  wire logic [7:0]             i_port_pin,
  output logic [7:0]                  o_port_out,
  output logic [7:0]                  o_port_oe
);
  localparam int NCH = 8;

  logic [7:0]    sel_ff;
  logic [7:0]    mask_ff;
  logic [7:0]    data_ff;
  logic [7:0]    port_ff;
  logic [7:0]    dir_ff;
  logic [15:0]   act_ff;
  logic [4:0]    ctl_ff;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] acc_ff;
  logic [7:0]    flag_ff;
  logic [CW-1:0] tc_ff [NCH];
  logic [7:0]    oc_ff;
  logic [4:0]    pre_ff;
  logic          new_ff;
  logic [31:0]   rd_ff;
  logic [7:0]    s1_ff;
  logic [7:0]    s2_ff;
  logic [7:0]    s3_ff;
  logic [7:0]    lvl_ff;

  logic          wr;
  logic          setup;
  logic [7:0]    force_v;
  logic [7:0]    match;
  logic [7:0]    edge_v;
  logic [7:0]    own;
  logic          hit7;
  logic          tick;
  logic [2:0]    pr;
  logic [7:0]    nxt_oc;
  logic [31:0]   nxt_rd;

  // Address decode for the error answer
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) &&
             ((a <= `TCMP_OFF_ACC) ||
              ((a >= `TCMP_OFF_TC0) && (a <= `TCMP_OFF_TC7)));
  endfunction

  function automatic logic [2:0] tc_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - `TCMP_OFF_TC0;
    tc_idx = d[4:2];
  endfunction

  function automatic logic is_tc(input logic [7:0] a);
    is_tc = (a >= `TCMP_OFF_TC0) && (a <= `TCMP_OFF_TC7) && (a[1:0] == 2'h0);
  endfunction

  // Output action on one compare output
  function automatic logic act_next(input logic cur, input logic [1:0] a);
    unique case (tcmp_pkg::tcmp_act_t'(a))
      tcmp_pkg::TCMP_ACT_OFF: act_next = cur;
      tcmp_pkg::TCMP_ACT_TGL: act_next = ~cur;
      tcmp_pkg::TCMP_ACT_CLR: act_next = 1'b0;
      tcmp_pkg::TCMP_ACT_SET: act_next = 1'b1;
    endcase
  endfunction

  // Zero-wait APB answer
  assign setup     = i_apb.psel & ~i_apb.penable;
  assign wr        = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_apb.psel & i_apb.penable & ~mapped(i_apb.paddr);
  assign o_prdata  = rd_ff;

  // Force bits live for the write cycle only
  assign force_v = (wr && i_apb.paddr == `TCMP_OFF_FORCE) ? i_apb.pwdata[7:0] : 8'h00;

  // Pin synchroniser; a change counts when stages two and three agree
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1_ff  <= 8'h00;
      s2_ff  <= 8'h00;
      s3_ff  <= 8'h00;
      lvl_ff <= 8'h00;
    end else begin
      s1_ff <= i_port_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < NCH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          lvl_ff[i] <= s3_ff[i];
        end
      end
    end
  end
  assign edge_v = ~(s2_ff ^ s3_ff) & (s3_ff ^ lvl_ff);

  // Prescaler: 2^pr module clocks per count
  assign pr   = (ctl_ff[`TCMP_CTL_PR_HI:`TCMP_CTL_PR_LO] > `TCMP_PR_MAX) ?
                `TCMP_PR_MAX : ctl_ff[`TCMP_CTL_PR_HI:`TCMP_CTL_PR_LO];
  assign tick = ctl_ff[`TCMP_CTL_EN] &&
                ((pre_ff & 5'((6'h01 << pr) - 6'h01)) == 5'h00);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pre_ff <= 5'h00;
      cnt_ff <= `TCMP_RST_WORD;
      new_ff <= 1'b0;
    end else begin
      new_ff <= tick;
      if (ctl_ff[`TCMP_CTL_EN]) begin
        pre_ff <= pre_ff + 5'h01;
      end
      if (tick) begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
  end

  // Compare once per new counter value
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      match[i] = sel_ff[i] & new_ff & (cnt_ff == tc_ff[i]);
    end
  end
  assign hit7 = match[7] | (force_v[7] & sel_ff[7]);

  // Compare outputs: own action, then channel-seven override
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      nxt_oc[i] = oc_ff[i];
      if (sel_ff[i] && (match[i] || force_v[i])) begin
        nxt_oc[i] = act_next(oc_ff[i], act_ff[2*i +: 2]);
      end
      if (hit7 && mask_ff[i]) begin
        nxt_oc[i] = data_ff[i];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      oc_ff <= `TCMP_RST_BYTE;
    end else begin
      oc_ff <= nxt_oc;
    end
  end

  // Pin ownership and drive
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      own[i] = sel_ff[i] & ((act_ff[2*i +: 2] != 2'h0) | mask_ff[i]);
    end
  end
  assign o_port_oe  = own | (~own & dir_ff);
  assign o_port_out = (own & oc_ff) | (~own & port_ff);

  // Software registers
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      sel_ff  <= `TCMP_RST_BYTE;
      mask_ff <= `TCMP_RST_BYTE;
      data_ff <= `TCMP_RST_BYTE;
      port_ff <= `TCMP_RST_BYTE;
      dir_ff  <= `TCMP_RST_BYTE;
      act_ff  <= `TCMP_RST_ACT;
      ctl_ff  <= `TCMP_RST_CTL;
    end else if (wr) begin
      unique case (i_apb.paddr)
        `TCMP_OFF_SEL:  sel_ff  <= i_apb.pwdata[7:0];
        `TCMP_OFF_MASK: mask_ff <= i_apb.pwdata[7:0];
        `TCMP_OFF_DATA: data_ff <= i_apb.pwdata[7:0];
        `TCMP_OFF_PORT: port_ff <= i_apb.pwdata[7:0];
        `TCMP_OFF_DIR:  dir_ff  <= i_apb.pwdata[7:0];
        `TCMP_OFF_ACT:  act_ff  <= i_apb.pwdata[15:0];
        `TCMP_OFF_CTL:  ctl_ff  <= i_apb.pwdata[4:0];
        default: ;
      endcase
    end
  end

  // Compare values and capture latches
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      for (int i = 0; i < NCH; i++) begin
        tc_ff[i] <= `TCMP_RST_WORD;
      end
    end else begin
      if (wr && is_tc(i_apb.paddr)) begin
        tc_ff[tc_idx(i_apb.paddr)] <= i_apb.pwdata[CW-1:0];
      end
      for (int i = 0; i < NCH; i++) begin
        if (!sel_ff[i] && edge_v[i]) begin
          tc_ff[i] <= cnt_ff;
        end
      end
    end
  end

  // Flags: hardware set wins over write-one clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      flag_ff <= `TCMP_RST_BYTE;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (match[i] || (!sel_ff[i] && edge_v[i])) begin
          flag_ff[i] <= 1'b1;
        end else if (wr && i_apb.paddr == `TCMP_OFF_FLAG && i_apb.pwdata[i]) begin
          flag_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Pulse accumulator on rising edges of pin 7
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      acc_ff <= `TCMP_RST_WORD;
    end else if (ctl_ff[`TCMP_CTL_ACC] && edge_v[7] && s3_ff[7]) begin
      acc_ff <= acc_ff + CW'(1);
    end
  end

  // Read data captured in the setup phase
  always_comb begin
    nxt_rd = 32'h0000_0000;
    if (is_tc(i_apb.paddr)) begin
      nxt_rd[CW-1:0] = tc_ff[tc_idx(i_apb.paddr)];
    end else begin
      unique case (i_apb.paddr)
        `TCMP_OFF_SEL:  nxt_rd[7:0]    = sel_ff;
        `TCMP_OFF_FORCE: nxt_rd        = 32'h0000_0000;
        `TCMP_OFF_MASK: nxt_rd[7:0]    = mask_ff;
        `TCMP_OFF_DATA: nxt_rd[7:0]    = data_ff;
        `TCMP_OFF_PORT: nxt_rd[7:0]    = (dir_ff & port_ff) | (~dir_ff & lvl_ff);
        `TCMP_OFF_DIR:  nxt_rd[7:0]    = dir_ff;
        `TCMP_OFF_ACT:  nxt_rd[15:0]   = act_ff;
        `TCMP_OFF_CTL:  nxt_rd[4:0]    = ctl_ff;
        `TCMP_OFF_CNT:  nxt_rd[CW-1:0] = cnt_ff;
        `TCMP_OFF_FLAG: nxt_rd[7:0]    = flag_ff;
        `TCMP_OFF_ACC:  nxt_rd[CW-1:0] = acc_ff;
        default:        nxt_rd         = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      rd_ff <= 32'h0000_0000;
    end else if (setup) begin
      rd_ff <= nxt_rd;
    end
  end

  // Checks
  a_count_step: assert property (@(posedge i_mclk) disable iff (i_rst)
    tick |=> cnt_ff == $past(cnt_ff) + CW'(1)) else $error("counter did not step");
  a_acc_step: assert property (@(posedge i_mclk) disable iff (i_rst)
    ctl_ff[`TCMP_CTL_ACC] && edge_v[7] && s3_ff[7] |=> acc_ff == $past(acc_ff) + CW'(1))
    else $error("accumulator did not step");
  a_gpio_idle: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_port_oe & ~own & ~dir_ff) == 8'h00) else $error("free pin driven");
  a_owned_drive: assert property (@(posedge i_mclk) disable iff (i_rst)
    ((o_port_out ^ oc_ff) & own) == 8'h00 && (o_port_oe & own) == own)
    else $error("owned pin not on compare output");
  a_latch_release: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 ($past(own) & ~own & dir_ff) != 8'h00 |->
    ((o_port_out ^ port_ff) & ~own) == 8'h00) else $error("latched data lost");
  a_capture_only: assert property (@(posedge i_mclk) disable iff (i_rst)
    (match & ~sel_ff) == 8'h00) else $error("capture channel compared");
  a_force_zero: assert property (@(posedge i_mclk) disable iff (i_rst)
    setup && i_apb.paddr == `TCMP_OFF_FORCE |=> o_prdata == 32'h0000_0000)
    else $error("force register read nonzero");
  a_force_noflag: assert property (@(posedge i_mclk) disable iff (i_rst)
    force_v != 8'h00 && match == 8'h00 && edge_v == 8'h00 |=> flag_ff <= $past(flag_ff))
    else $error("force set a flag");
  a_mask_output: assert property (@(posedge i_mclk) disable iff (i_rst)
    (o_port_oe & mask_ff & sel_ff) == (mask_ff & sel_ff)) else $error("masked pin not output");
  a_seven_data: assert property (@(posedge i_mclk) disable iff (i_rst)
    hit7 |=> ((oc_ff ^ $past(data_ff)) & $past(mask_ff)) == 8'h00)
    else $error("channel seven data not copied");
  a_toggle_one: assert property (@(posedge i_mclk) disable iff (i_rst)
    match[0] && act_ff[1:0] == 2'h1 && !(hit7 && mask_ff[0]) |=> oc_ff[0] != $past(oc_ff[0]))
    else $error("toggle action missed");
  a_match_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
    match[0] |=> flag_ff[0]) else $error("match flag not set");
  a_reset_clear: assert property (@(posedge i_mclk)
    i_rst |=> sel_ff == 8'h00 && mask_ff == 8'h00 && o_port_oe == 8'h00)
    else $error("reset left pins driven");

  // Software writes, forced actions and capture
  a_select_write: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr && i_apb.paddr == `TCMP_OFF_SEL |=> sel_ff == $past(i_apb.pwdata[7:0]))
    else $error("select write lost");
  a_port_store: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr && i_apb.paddr == `TCMP_OFF_PORT |=> port_ff == $past(i_apb.pwdata[7:0]))
    else $error("port latch write lost");
  a_dir_keep: assert property (@(posedge i_mclk) disable iff (i_rst)
    !(wr && i_apb.paddr == `TCMP_OFF_DIR) |=> dir_ff == $past(dir_ff))
    else $error("direction changed without write");
  a_force_set: assert property (@(posedge i_mclk) disable iff (i_rst)
    force_v[0] && sel_ff[0] && act_ff[1:0] == 2'h3 && !(hit7 && mask_ff[0]) |=> oc_ff[0])
    else $error("forced set missed");
  a_clear_one: assert property (@(posedge i_mclk) disable iff (i_rst)
    (match[1] || force_v[1]) && sel_ff[1] && act_ff[3:2] == 2'h2 && !(hit7 && mask_ff[1])
    |=> !oc_ff[1]) else $error("clear action missed");
  a_toggle_two: assert property (@(posedge i_mclk) disable iff (i_rst)
    (match[2] || force_v[2]) && sel_ff[2] && act_ff[5:4] == 2'h1 && !(hit7 && mask_ff[2])
    |=> oc_ff[2] != $past(oc_ff[2])) else $error("forced toggle missed");
  a_capture_take: assert property (@(posedge i_mclk) disable iff (i_rst)
    !sel_ff[6] && edge_v[6] |=> tc_ff[6] == $past(cnt_ff) && flag_ff[6])
    else $error("capture not taken");
endmodule
`default_nettype wire

// ---- test/tcmp_pin_model.sv ----
// Behavioural timer port pins seen from outside the device.
// Assumes the device drives a pin only while its output enable is high.
`timescale 1ns/10ps
`default_nettype none
module tcmp_pin_model (
  // Clock
  input  wire logic       i_mclk,
  // Device side
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  // External drivers
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  // Resolved pin levels
  output logic [7:0]      o_pin
);
  logic [7:0] float_ff = 8'hA5;
  // Undriven pins wander so a stale level is never trusted
  always_ff @(posedge i_mclk) begin
    float_ff <= float_ff + 8'h5B;
  end
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext) | (~i_oe & ~i_ext_en & float_ff);
endmodule
`default_nettype wire

// ---- test/test_timer_compare_port_control.sv ----
// Bench for the compare timer: APB register tests and port pin checks.
// Assumes the design package, header and pin model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_timer_compare_port_control;
  logic                   i_mclk;
  logic                   i_rst;
  tcmp_pkg::tcmp_apb_req_t req;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic [7:0]             pin;
  logic [7:0]             pout;
  logic [7:0]             poe;
  int                     fail_count = 0;
  int                     samples_checked = 0;
  int                     cyc = 0;
  logic [31:0]            r;
  logic                   e;
  int                     n;
  logic [7:0]             ext;
  logic [7:0]             ext_en;
  tcmp_timer uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_apb(req), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_port_pin(pin), .o_port_out(pout),
    .o_port_oe(poe));
  tcmp_pin_model pins (.i_mclk(i_mclk), .i_out(pout), .i_oe(poe), .i_ext(ext),
    .i_ext_en(ext_en), .o_pin(pin));
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      $display("Error at %0t: %s seen %h expected %h", $time, m, seen, exp);
      fail_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge i_mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    req <= '0;
    @(negedge i_mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp, "register read");
  endtask
  initial begin
    req = '0;
    ext = 8'h40;
    ext_en = 8'h40;
    i_rst = 1'b1;
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    chk({30'h0, pready, e}, 32'h2, "mapped access answer");
    chk({24'h0, poe}, 32'h0, "no pin driven after reset");
    apb(1'b0, 8'h10, 32'h0);
    chk(r & 32'h40, 32'h40, "pin level read as input");
    apb(1'b0, 8'h30, 32'h0);
    chk({r[30:0], e}, 32'h1, "unmapped read");
    $display("test done: reset and bus");
    wr(8'h00, 32'hFF);
    wr(8'h24, 32'hFF);
    rd(8'h00, 32'hFF);
    wr(8'h18, 32'h1B);
    wr(8'h14, 32'h00);
    wr(8'h10, 32'hFF);
    chk({24'h0, poe & 8'h0F}, 32'h07, "owned pins ignore direction");
    wr(8'h04, 32'h0F);
    rd(8'h04, 32'h0);
    chk({24'h0, pout & 8'h07}, 32'h05, "forced actions");
    rd(8'h24, 32'h0);
    wr(8'h04, 32'h04);
    chk({24'h0, pout & 8'h04}, 32'h0, "second toggle");
    $display("test done: force actions");
    wr(8'h14, 32'h0F);
    chk({24'h0, poe & pout & 8'h0A}, 32'h08, "latch held off owned pin");
    wr(8'h18, 32'h13);
    chk({24'h0, poe & pout & 8'h0A}, 32'h0A, "latch reaches freed pin");
    $display("test done: port latch");
    wr(8'h14, 32'h00);
    wr(8'h08, 32'h12);
    wr(8'h0C, 32'h12);
    wr(8'h18, 32'h1B);
    chk({24'h0, poe & 8'h12}, 32'h12, "mask makes outputs");
    rd(8'h14, 32'h0);
    wr(8'h04, 32'h82);
    chk({24'h0, pout & 8'h12}, 32'h12, "channel seven data wins");
    $display("test done: channel seven mask");
    wr(8'h40, 32'h30);
    wr(8'h18, 32'h19);
    wr(8'h24, 32'hFF);
    wr(8'h1C, 32'h01);
    n = 0;
    do begin
      apb(1'b0, 8'h24, 32'h0);
      n++;
    end while (r[0] !== 1'b1 && n < 100);
    chk(r & 32'h1, 32'h1, "compare flag");
    chk({31'h0, pout[0]}, 32'h0, "compare toggles pin");
    $display("test done: compare match");
    @(posedge i_mclk);
    ext_en <= 8'hC0;
    repeat (6) @(posedge i_mclk);
    wr(8'h1C, 32'h11);
    repeat (3) begin
      @(posedge i_mclk);
      ext <= 8'hC0;
      repeat (5) @(posedge i_mclk);
      ext <= 8'h40;
      repeat (5) @(posedge i_mclk);
    end
    rd(8'h28, 32'h3);
    $display("test done: pulse accumulator");
    wr(8'h00, 32'hBF);
    wr(8'h24, 32'hFF);
    @(posedge i_mclk);
    ext <= 8'h00;
    repeat (6) @(posedge i_mclk);
    rd(8'h24, 32'h40);
    $display("test done: input capture");
    print_verdict();
  end
endmodule
`default_nettype wire
